/* File: rtl/trc_pkg.sv */
/*
 Constants and types for the trip reset / restart controller.
 Assumes the user of each constant writes trc_pkg::name.
*/
package trc_pkg;
    localparam logic [1:0] RESET_ON_RISE_STOP  = 2'h0;
    localparam logic [1:0] RESET_ON_FALL_STOP  = 2'h1;
    localparam logic [1:0] RESET_ON_RISE_NORUN = 2'h2;
    localparam logic [1:0] RESET_RESP_DEFAULT  = 2'h0;
    localparam logic       RESTART_ZERO_HZ     = 1'h0;
    localparam logic       RESTART_FREQ_MATCH  = 1'h1;
    localparam logic       RESTART_DEFAULT     = 1'h0;
    localparam int         FREQ_W              = 16;
    localparam logic [15:0] ZERO_FREQ          = 16'h0000;

    typedef enum logic [2:0] {
        TRC_IDLE    = 3'h0,
        TRC_RUN     = 3'h1,
        TRC_TRIPPED = 3'h3,
        TRC_MATCH   = 3'h2,
        TRC_RAMP    = 3'h6
    } trc_state_e;
endpackage

/* File: rtl/trc_edge_if.sv */
/*
 Edge events of the reset request, passed from detector to controller.
 Assumes one clock domain.
*/
`timescale 1ns/1ps
interface trc_edge_if;
    logic rise;
    logic fall;
    modport src (output rise, output fall);
    modport dst (input rise, input fall);
endinterface

/* File: rtl/trc_edge_det.sv */
/*
 Synchroniser and edge detector for the reset request.
 Assumes the input is asynchronous to clock_i.
*/
`timescale 1ns/1ps
module trc_edge_det (
    input  wire logic  clock_i,
    input  wire logic  rst_b_i,
    input  wire logic  level_i,
    trc_edge_if.src    edge_o
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg  <= 1'b0;
        end else begin
            sync1_reg <= level_i;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    assign edge_o.rise = sync2_reg & ~prev_reg;
    assign edge_o.fall = ~sync2_reg & prev_reg;
endmodule

/* File: rtl/trc_top.sv */
/*
 Trip reset and restart control of a motor drive output stage.
 Assumes trip_i, run_cmd_i and settings are on clock_i; pin inputs
 (reset input, keypad key) are asynchronous and synchronised here.
*/
// Function
// - A trip turns the drive output off at once with no ramp.
// - A trip while running lets the motor coast with no braking.
// - The reset input or the keypad stop/reset key may cancel a trip per the response setting.
// - Setting 00 clears the trip on the rising edge and stops a running drive.
// - Setting 01 clears the trip on the falling edge and stops a running drive.
// - Setting 02 clears the trip on the rising edge and ignores a request while running.
// - Restart setting 00 restarts from zero frequency and ramps normally.
// - Restart setting 01 first matches the coasting motor's frequency then continues.
// - Both settings default to 00 out of reset.
`timescale 1ns/1ps
module trc_top (
    input  wire logic                        clock_i,
    input  wire logic                        rst_b_i,
    input  wire logic                        trip_i,
    input  wire logic                        run_cmd_i,
    input  wire logic                        trip_reset_input_i,
    input  wire logic                        keypad_reset_i,
    input  wire logic                        settings_load_i,
    input  wire logic [1:0]                  reset_response_select_i,
    input  wire logic                        restart_after_reset_select_i,
    input  wire logic [trc_pkg::FREQ_W-1:0]  target_freq_i,
    input  wire logic [trc_pkg::FREQ_W-1:0]  motor_freq_i,
    input  wire logic                        ramp_step_i,
    output logic                             drive_enable_o,
    output logic                             coasting_o,
    output logic                             tripped_o,
    output logic                             running_o,
    output logic [trc_pkg::FREQ_W-1:0]       out_freq_o
);
    // Edge events from the two request sources
    trc_edge_if rs_edge ();
    trc_edge_if key_edge ();

    // Both pins are asynchronous; each detector holds its own synchroniser
    trc_edge_det u_rs_det (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .level_i (trip_reset_input_i),
        .edge_o  (rs_edge)
    );

    trc_edge_det u_key_det (
        .clock_i (clock_i),
        .rst_b_i (rst_b_i),
        .level_i (keypad_reset_i),
        .edge_o  (key_edge)
    );

    logic [1:0]                 resp_reg;
    logic                       restart_reg;
    trc_pkg::trc_state_e        state_reg;
    logic [trc_pkg::FREQ_W-1:0] freq_reg;
    logic                       coast_reg;
    logic                       req_rise;
    logic                       req_fall;
    logic                       clear_req;
    logic                       stop_req;
    logic                       at_target;
    logic                       stop_hold_reg;

    // Output stage is live in these states
    function automatic logic drives_motor(input trc_pkg::trc_state_e st);
        return st == trc_pkg::TRC_RUN || st == trc_pkg::TRC_RAMP || st == trc_pkg::TRC_MATCH;
    endfunction

    // Settings latched only on load so mid-sequence changes stay coherent
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            resp_reg    <= trc_pkg::RESET_RESP_DEFAULT;
            restart_reg <= trc_pkg::RESTART_DEFAULT;
        end else if (settings_load_i) begin
            resp_reg    <= reset_response_select_i;
            restart_reg <= restart_after_reset_select_i;
        end
    end

    // Keypad key shares the pin's edge mode
    assign req_rise = rs_edge.rise | key_edge.rise;

    assign req_fall = rs_edge.fall | key_edge.fall;

    assign at_target = freq_reg == target_freq_i;

    // Code 03 is unused and treated like the rising-edge mode
    always_comb begin
        clear_req = 1'b0;
        stop_req  = 1'b0;
        case (resp_reg)
            trc_pkg::RESET_ON_FALL_STOP: begin
                clear_req = req_fall;
                stop_req  = req_fall;
            end
            trc_pkg::RESET_ON_RISE_NORUN: begin
                clear_req = req_rise;
                stop_req  = 1'b0;
            end
            default: begin
                clear_req = req_rise;
                stop_req  = req_rise;
            end
        endcase
    end

    // Trip outranks every other transition
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= trc_pkg::TRC_IDLE;
        end else if (trip_i) begin
            state_reg <= trc_pkg::TRC_TRIPPED;
        end else begin
            case (state_reg)
                trc_pkg::TRC_IDLE: begin
                    if (run_cmd_i && !stop_hold_reg) begin
                        state_reg <= trc_pkg::TRC_RAMP;
                    end
                end
                trc_pkg::TRC_TRIPPED: begin
                    if (clear_req && !run_cmd_i) begin
                        state_reg <= trc_pkg::TRC_IDLE;
                    end else if (clear_req && restart_reg == trc_pkg::RESTART_FREQ_MATCH) begin
                        state_reg <= trc_pkg::TRC_MATCH;
                    end else if (clear_req) begin
                        state_reg <= trc_pkg::TRC_RAMP;
                    end
                end
                trc_pkg::TRC_MATCH: begin
                    state_reg <= trc_pkg::TRC_RAMP;
                end
                trc_pkg::TRC_RAMP,
                trc_pkg::TRC_RUN: begin
                    if (!run_cmd_i || stop_req) begin
                        state_reg <= trc_pkg::TRC_IDLE;
                    end else if (at_target) begin
                        state_reg <= trc_pkg::TRC_RUN;
                    end else begin
                        state_reg <= trc_pkg::TRC_RAMP;
                    end
                end
                default: begin
                    state_reg <= trc_pkg::TRC_IDLE;
                end
            endcase
        end
    end

    // Coasting remembers a trip from run until a clear request arrives in the tripped state
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            coast_reg <= 1'b0;
        end else if (trip_i && drives_motor(state_reg)) begin
            coast_reg <= 1'b1;
        end else if (state_reg == trc_pkg::TRC_TRIPPED && clear_req) begin
            coast_reg <= 1'b0;
        end
    end

    // A reset-key stop holds until the run command is withdrawn
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stop_hold_reg <= 1'b0;
        end else if (stop_req && (state_reg == trc_pkg::TRC_RUN
                     || state_reg == trc_pkg::TRC_RAMP)) begin
            stop_hold_reg <= 1'b1;
        end else if (!run_cmd_i) begin
            stop_hold_reg <= 1'b0;
        end
    end

    // One unit per ramp enable; the match load replaces the count
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            freq_reg <= trc_pkg::ZERO_FREQ;
        end else if (trip_i || state_reg == trc_pkg::TRC_IDLE
                     || state_reg == trc_pkg::TRC_TRIPPED) begin
            freq_reg <= trc_pkg::ZERO_FREQ;
        end else if (state_reg == trc_pkg::TRC_MATCH) begin
            freq_reg <= motor_freq_i;
        end else if (ramp_step_i && freq_reg < target_freq_i) begin
            freq_reg <= freq_reg + 16'h0001;
        end else if (ramp_step_i && freq_reg > target_freq_i) begin
            freq_reg <= freq_reg - 16'h0001;
        end
    end

    // Enable drops in the same edge as the trip, no ramp-down
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            drive_enable_o <= 1'b0;
        end else begin
            drive_enable_o <= ~trip_i & drives_motor(state_reg);
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_freq_o <= trc_pkg::ZERO_FREQ;
        end else begin
            out_freq_o <= trip_i ? trc_pkg::ZERO_FREQ : freq_reg;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            coasting_o <= 1'b0;
        end else begin
            coasting_o <= coast_reg;
        end
    end

    // Flags follow the state one edge later, like the drive enable
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tripped_o <= 1'b0;
        end else begin
            tripped_o <= state_reg == trc_pkg::TRC_TRIPPED;
        end
    end

    // A trip in the same edge already ends the run
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            running_o <= 1'b0;
        end else begin
            running_o <= ~trip_i & (state_reg == trc_pkg::TRC_RUN);
        end
    end
endmodule

/* File: test/trc_top_monitor.sv */
/* Port checker for trc_top.
 Assumes it is bound to trc_top below. */
`timescale 1ns/1ps
module trc_top_monitor (
    input wire logic                       clock_i,
    input wire logic                       rst_b_i,
    input wire logic                       trip_i,
    input wire logic                       trip_reset_input_i,
    input wire logic                       keypad_reset_i,
    input wire logic                       ramp_step_i,
    input wire logic [trc_pkg::FREQ_W-1:0] target_freq_i,
    input wire logic [trc_pkg::FREQ_W-1:0] motor_freq_i,
    input wire logic                       drive_enable_o,
    input wire logic                       coasting_o,
    input wire logic                       tripped_o,
    input wire logic                       running_o,
    input wire logic [trc_pkg::FREQ_W-1:0] out_freq_o
);
    logic [2:0] since_reg;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    // Saturates so a stale request can never explain a late clear
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i)
            since_reg <= 3'h7;
        else if ($changed({trip_reset_input_i, keypad_reset_i}))
            since_reg <= 3'h0;
        else if (since_reg != 3'h7)
            since_reg <= since_reg + 3'h1;
    end
    trip_off_a: assert property (trip_i |=> !drive_enable_o && out_freq_o == 16'h0000)
        else $error("drive on after trip");
    trip_flag_a: assert property (trip_i |-> ##2 tripped_o)
        else $error("trip flag late");
    coast_flag_a: assert property (trip_i && drive_enable_o |-> ##2 coasting_o)
        else $error("no coast after trip");
    coast_free_a: assert property (coasting_o |-> !drive_enable_o && $stable(out_freq_o))
        else $error("coast driven");
    trip_zero_a: assert property (tripped_o |-> !drive_enable_o && out_freq_o == 16'h0000)
        else $error("output live in trip");
    ramp_gate_a: assert property (drive_enable_o && $past(drive_enable_o) && $changed(out_freq_o)
        |-> ((($past(ramp_step_i) || $past(ramp_step_i, 2)) && (out_freq_o == $past(out_freq_o)
        + 16'h0001 || out_freq_o + 16'h0001 == $past(out_freq_o)))
        || (!$past(drive_enable_o, 2) && out_freq_o == motor_freq_i))) else $error("bad ramp step");
    clear_time_a: assert property ($fell(tripped_o) |-> since_reg inside {[3'h1:3'h6]})
        else $error("clear without request edge");
    run_target_a: assert property (running_o |-> drive_enable_o && out_freq_o == target_freq_i)
        else $error("running off target");
endmodule
bind trc_top trc_top_monitor u_trc_top_monitor (.clock_i(clock_i), .rst_b_i(rst_b_i),
    .trip_i(trip_i), .trip_reset_input_i(trip_reset_input_i), .keypad_reset_i(keypad_reset_i),
    .ramp_step_i(ramp_step_i), .target_freq_i(target_freq_i), .motor_freq_i(motor_freq_i),
    .drive_enable_o(drive_enable_o),
    .coasting_o(coasting_o), .tripped_o(tripped_o), .running_o(running_o),
    .out_freq_o(out_freq_o));

/* File: test/trc_operator.sv */
/* Operator model: holds the reset pin or the keypad key for a set time.
 Assumes one request at a time. */
`timescale 1ns/1ps
module trc_operator (
    input  wire logic       clock_i,
    input  wire logic       req_i,
    input  wire logic       key_i,
    input  wire logic [3:0] len_i,
    output logic            pin_o,
    output logic            key_o
);
    logic [3:0] hold_reg = 4'h0;
    logic       sel_reg  = 1'h0;
    always @(posedge clock_i) begin
        if (req_i) begin
            hold_reg <= len_i;
            sel_reg <= key_i;
        end else if (hold_reg != 4'h0)
            hold_reg <= hold_reg - 4'h1;
    end
    // Released lines return to inactive low
    assign pin_o = hold_reg != 4'h0 && !sel_reg;
    assign key_o = hold_reg != 4'h0 && sel_reg;
endmodule

/* File: test/test_trc_top.sv */
/* Bench for trc_top: trip, clear in each reset mode, restart, run stop.
 Assumes trc_top, trc_operator and the checker are compiled first. */
`timescale 1ns/1ps
module test_trc_top;
    logic        clock_i = 1'h0, rst_b_i = 1'h0, trip = 1'h0, run = 1'h0, load = 1'h0;
    logic        step = 1'h0, restart = 1'h1, req = 1'h0, ksel = 1'h0, look = 1'h0;
    logic [1:0]  mode = 2'h1;
    logic [3:0]  len = 4'h0;
    logic [15:0] tgt = 16'h0, mf = 16'h0, freq;
    logic        pin, key, de, co, tr, ru;
    logic [18:0] notes[$];
    int          n_errors = 0, checks = 0;
    always #2.5 clock_i = ~clock_i;
    trc_top u_trc_top (.clock_i(clock_i), .rst_b_i(rst_b_i), .trip_i(trip), .run_cmd_i(run),
        .trip_reset_input_i(pin), .keypad_reset_i(key), .settings_load_i(load),
        .reset_response_select_i(mode), .restart_after_reset_select_i(restart),
        .target_freq_i(tgt), .motor_freq_i(mf), .ramp_step_i(step), .drive_enable_o(de),
        .coasting_o(co), .tripped_o(tr), .running_o(ru), .out_freq_o(freq));
    trc_operator u_trc_operator (.clock_i(clock_i), .req_i(req), .key_i(ksel), .len_i(len),
        .pin_o(pin), .key_o(key));
    task automatic conclude;
        if (n_errors == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    task automatic note(input logic [18:0] e);
        notes.push_back(e);
        look <= 1'h1;
        tick(1);
        look <= 1'h0;
    endtask
    task automatic check(input string what, input logic [18:0] seen, input logic [18:0] want);
        checks++;
        if (seen !== want) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, want, seen);
        end
    endtask
    always @(negedge clock_i) begin
        if (look === 1'h1) begin
            check("outputs", {de, co, tr, freq}, notes.pop_front());
        end
    end
    task automatic press(input logic k, input logic [3:0] n);
        req <= 1'h1;
        ksel <= k;
        len <= n;
        tick(1);
        req <= 1'h0;
        tick(8);
    endtask
    task automatic run_up;
        run <= 1'h0;
        tick(3);
        run <= 1'h1;
        tick(2);
        for (int i = 0; i < 40 && ru !== 1'h1; i++) begin
            step <= 1'h1;
            tick(1);
            step <= 1'h0;
            tick(3);
        end
        if (ru !== 1'h1) begin
            check("running", {18'h0, ru}, 19'h1);
            conclude();
        end
    endtask
    // Without a load the selects show other codes, so only the defaults give m and rs
    task automatic trip_case(input logic [1:0] m, input logic rs, input logic k, input logic ld);
        mode <= ld ? m : 2'h1;
        restart <= ld ? rs : 1'h1;
        load <= ld;
        tick(1);
        load <= 1'h0;
        run_up();
        trip <= 1'h1;
        tick(1);
        trip <= 1'h0;
        tick(2);
        note({3'h3, 16'h0000});
        press(k, 4'hC);
        note((m == 2'h1) ? {3'h3, 16'h0000} : {3'h4, rs ? mf : 16'h0000});
        tick(10);
        if (m == 2'h1)
            note({3'h4, mf});
    endtask
    initial begin
        void'($urandom(81));
        tgt <= 16'($urandom_range(20, 8));
        mf <= 16'($urandom_range(6, 1));
        tick(4);
        rst_b_i <= 1'h1;
        trip_case(2'h0, 1'h0, 1'h0, 1'h0);
        trip_case(2'h1, 1'h1, 1'h0, 1'h1);
        trip_case(2'h2, 1'h0, 1'h1, 1'h1);
        run_up();
        press(1'h0, 4'h3);
        note({3'h4, tgt});
        trip_case(2'h0, 1'h0, 1'h0, 1'h1);
        run_up();
        press(1'h1, 4'h3);
        note({3'h0, 16'h0000});
        mode <= 2'h1;
        load <= 1'h1;
        tick(1);
        load <= 1'h0;
        run_up();
        press(1'h0, 4'h3);
        note({3'h0, 16'h0000});
        tick(4);
        conclude();
    end
endmodule
